// ### logic/sac_pkg.sv
package sac_pkg;

  // --------------------------------------------------------------
  // Register offsets and reset values
  // --------------------------------------------------------------
  localparam logic [7:0] CFG_OFFSET = 8'hBC;
  localparam logic [7:0] HV_OFFSET = 8'hD6;
  localparam logic [7:0] CTRL_OFFSET = 8'hE8;
  localparam logic [7:0] RES_HIGH_OFFSET = 8'hBF;
  localparam logic [7:0] RES_LOW_OFFSET = 8'hBE;
  localparam logic [7:0] CFG_RESET = 8'hF8;
  localparam logic [7:0] HV_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // --------------------------------------------------------------
  // Control and amplifier register field positions
  // --------------------------------------------------------------
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_TM_BIT = 6;
  localparam int CTRL_DONE_BIT = 5;
  localparam int CTRL_BUSY_BIT = 4;
  localparam int CTRL_SRC_LSB = 2;
  localparam int CTRL_WIN_BIT = 1;
  localparam int CTRL_LJST_BIT = 0;
  localparam int HV_EN_BIT = 7;

  // --------------------------------------------------------------
  // Timing counts, in SAR clocks, and the maximum rate in ksps
  // --------------------------------------------------------------
  localparam logic [3:0] LP_TRACK_SAR_CLKS = 4'h3;
  localparam int MAX_RATE_KSPS = 100;

  // Start source encodings
  localparam logic [1:0] SRC_SOFT = 2'b00;
  localparam logic [1:0] SRC_TIMER_B = 2'b01;
  localparam logic [1:0] SRC_STROBE = 2'b10;
  localparam logic [1:0] SRC_TIMER_A = 2'b11;

  // Gains in thousandths
  localparam logic [13:0] HV_GAIN_MILLI [16] = '{
    14'h0032, 14'h0064, 14'h007D, 14'h00C8, 14'h00FA, 14'h0190, 14'h01F4, 14'h0320,
    14'h03E8, 14'h0640, 14'h07D0, 14'h0C80, 14'h0FA0, 14'h1838, 14'h1DB0, 14'h36B0};
  localparam logic [13:0] PGA_GAIN_MILLI [8] = '{
    14'h03E8, 14'h07D0, 14'h0FA0, 14'h1F40, 14'h3E80, 14'h3E80, 14'h01F4, 14'h01F4};

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_TRACK = 2'b01,
    ST_CONV = 2'b11
  } sac_state_e;

  // Place a 10-bit result in the 16-bit register pair
  function automatic logic [15:0] sac_justify(logic [9:0] res, logic diff, logic lj);
    if (lj) begin
      return {res, 6'h00};
    end
    return {{6{diff & res[9]}}, res};
  endfunction

endpackage

// ### logic/sac_sequencer.sv
`timescale 1ns/1ps
module sac_sequencer import sac_pkg::*; #(
  parameter int CONV_SAR_CLKS = 11
) (
  input wire logic clk, // Core clock, 20 MHz
  input wire logic rst_b, // Asynchronous reset, active low
  input wire logic [7:0] regAddr, // Register address
  input wire logic regWrEn, // Register write strobe
  input wire logic [7:0] regWrData, // Register write data
  output logic [7:0] regRdData, // Read data, one cycle after address
  input wire logic timerAOvf, // First timer overflow pulse
  input wire logic timerBOvf, // Second timer overflow pulse
  input wire logic extConvStrobe, // External convert strobe level
  input wire logic [9:0] analogResult, // Converted code from front end
  input wire logic diffMode, // Differential reading selected
  input wire logic [15:0] ltLimit, // Less-than window limit
  input wire logic [15:0] gtLimit, // Greater-than window limit
  input wire logic convIrqEnable, // Completion interrupt enabled
  output logic convIrq, // Completion interrupt request pulse
  output logic hvAmpEnable, // Difference amplifier power
  output logic [13:0] hvAmpGainMilli, // Amplifier gain, thousandths
  output logic [13:0] pgaGainMilli, // Converter gain, thousandths
  output logic converterPowered, // Converter out of shutdown
  output logic trackOn, // Input tracking switch closed
  output logic convActive, // SAR conversion running
  output logic sarTick // One-cycle SAR clock enable
);

  // --------------------------------------------------------------
  // State record
  // --------------------------------------------------------------
  typedef struct packed {
    logic hvEn;
    logic [3:0] hvGain;
    logic [4:0] sarDiv;
    logic [2:0] pga;
    logic cnEn;
    logic tm;
    logic done;
    logic [1:0] src;
    logic win;
    logic ljst;
    sac_state_e fsm;
    logic [4:0] divCnt;
    logic [3:0] stepCnt;
    logic strobePrev;
    logic [9:0] result;
    logic resDiff;
    logic [7:0] rdData;
    logic irq;
    logic trackOn;
    logic tick;
    logic conv;
    logic [13:0] hvMilli;
    logic [13:0] pgaMilli;
  } sac_state_s;

  sac_state_s st_r;
  sac_state_s st_nxt;

  logic wrCtrl;
  logic wrHv;
  logic wrCfg;
  logic strobeRise;
  logic startEv;
  logic tickNow;
  logic convEnd;
  logic [15:0] word;
  logic winHit;
  logic busyNow;
  logic [15:0] resWord;

  // Decoded writes and start event
  assign wrCtrl = regWrEn && regAddr == CTRL_OFFSET;
  assign wrHv = regWrEn && regAddr == HV_OFFSET;
  assign wrCfg = regWrEn && regAddr == CFG_OFFSET;
  assign strobeRise = extConvStrobe && !st_r.strobePrev;
  assign busyNow = st_r.fsm != ST_IDLE;

  // Stored result laid out once, so both result bytes come from one word
  assign resWord = sac_justify(st_r.result, st_r.resDiff, st_r.ljst);

  // Start source choice; a disabled or busy converter ignores starts
  always_comb begin
    case (st_r.src)
      SRC_SOFT: startEv = wrCtrl && regWrData[CTRL_BUSY_BIT];
      SRC_TIMER_B: startEv = timerBOvf;
      SRC_STROBE: startEv = strobeRise;
      SRC_TIMER_A: startEv = timerAOvf;
      default: startEv = 1'b0;
    endcase
    startEv = startEv && st_r.cnEn && st_r.fsm == ST_IDLE;
  end

  // SAR clock enable: divider runs only while a conversion is owed
  assign tickNow = st_r.fsm != ST_IDLE && st_r.divCnt == st_r.sarDiv;
  assign convEnd = st_r.cnEn && st_r.fsm == ST_CONV && tickNow && st_r.stepCnt == 4'(CONV_SAR_CLKS - 1);

  // Window compare on the freshly justified word, two's complement
  always_comb begin
    word = sac_justify(analogResult, diffMode, st_r.ljst);
    if ($signed(ltLimit) > $signed(gtLimit)) begin
      winHit = $signed(word) < $signed(ltLimit) && $signed(word) > $signed(gtLimit);
    end else begin
      winHit = $signed(word) < $signed(ltLimit) || $signed(word) > $signed(gtLimit);
    end
  end

  // --------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.strobePrev = extConvStrobe;
    st_nxt.irq = 1'b0;
    // Register writes
    if (wrHv) begin
      st_nxt.hvEn = regWrData[HV_EN_BIT];
      st_nxt.hvGain = regWrData[3:0];
    end
    if (wrCfg) begin
      st_nxt.sarDiv = regWrData[7:3];
      st_nxt.pga = regWrData[2:0];
    end
    if (wrCtrl) begin
      st_nxt.cnEn = regWrData[CTRL_EN_BIT];
      st_nxt.tm = regWrData[CTRL_TM_BIT];
      st_nxt.done = regWrData[CTRL_DONE_BIT];
      st_nxt.src = regWrData[CTRL_SRC_LSB +: 2];
      st_nxt.win = regWrData[CTRL_WIN_BIT];
      st_nxt.ljst = regWrData[CTRL_LJST_BIT];
    end
    // Divider advances while tracking or converting
    if (st_r.fsm == ST_IDLE || tickNow) begin
      st_nxt.divCnt = 5'h00;
    end else begin
      st_nxt.divCnt = st_r.divCnt + 5'h01;
    end
    // Sequencer
    case (st_r.fsm)
      ST_IDLE: begin
        st_nxt.stepCnt = 4'h0;
        if (startEv) begin
          // Strobe starts skip the fixed track: tracking happened while low
          if (st_r.tm && st_r.src != SRC_STROBE) begin
            st_nxt.fsm = ST_TRACK;
          end else begin
            st_nxt.fsm = ST_CONV;
          end
        end
      end
      ST_TRACK: begin
        if (tickNow) begin
          if (st_r.stepCnt == LP_TRACK_SAR_CLKS - 4'h1) begin
            st_nxt.fsm = ST_CONV;
            st_nxt.stepCnt = 4'h0;
          end else begin
            st_nxt.stepCnt = st_r.stepCnt + 4'h1;
          end
        end
      end
      ST_CONV: begin
        if (convEnd) begin
          st_nxt.fsm = ST_IDLE;
          st_nxt.result = analogResult;
          st_nxt.resDiff = diffMode;
          st_nxt.done = 1'b1;
          st_nxt.irq = convIrqEnable;
          if (winHit) begin
            st_nxt.win = 1'b1;
          end
        end else if (tickNow) begin
          st_nxt.stepCnt = st_r.stepCnt + 4'h1;
        end
      end
      default: st_nxt.fsm = ST_IDLE;
    endcase
    // Shutdown aborts a conversion without touching the flags
    if (!st_r.cnEn) begin
      st_nxt.fsm = ST_IDLE;
    end
    // Tracking switch for the front end
    st_nxt.trackOn = st_nxt.cnEn && ((!st_nxt.tm && st_nxt.fsm != ST_CONV) ||
      (st_nxt.tm && (st_nxt.fsm == ST_TRACK ||
      (st_nxt.src == SRC_STROBE && st_nxt.fsm == ST_IDLE && !extConvStrobe))));
    st_nxt.tick = st_nxt.fsm != ST_IDLE && st_nxt.divCnt == st_nxt.sarDiv;
    st_nxt.conv = st_nxt.fsm == ST_CONV;
    st_nxt.hvMilli = HV_GAIN_MILLI[st_nxt.hvGain];
    st_nxt.pgaMilli = PGA_GAIN_MILLI[st_nxt.pga];
    // Read data follows the address by one cycle
    case (regAddr)
      CTRL_OFFSET: st_nxt.rdData = {st_r.cnEn, st_r.tm, st_r.done, busyNow,
        st_r.src, st_r.win, st_r.ljst};
      HV_OFFSET: st_nxt.rdData = {st_r.hvEn, 3'b000, st_r.hvGain};
      CFG_OFFSET: st_nxt.rdData = {st_r.sarDiv, st_r.pga};
      RES_HIGH_OFFSET: st_nxt.rdData = resWord[15:8];
      RES_LOW_OFFSET: st_nxt.rdData = resWord[7:0];
      default: st_nxt.rdData = 8'h00;
    endcase
  end

  // --------------------------------------------------------------
  // State register
  // --------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '{hvEn: HV_RESET[7], hvGain: HV_RESET[3:0], sarDiv: CFG_RESET[7:3], pga: CFG_RESET[2:0],
        cnEn: CTRL_RESET[7], tm: CTRL_RESET[6], done: CTRL_RESET[5], src: CTRL_RESET[3:2],
        win: CTRL_RESET[1], ljst: CTRL_RESET[0], fsm: ST_IDLE, divCnt: 5'h00, stepCnt: 4'h0,
        strobePrev: 1'b0, result: 10'h000, resDiff: 1'b0, rdData: 8'h00, irq: 1'b0,
        trackOn: 1'b0, tick: 1'b0, conv: 1'b0, hvMilli: HV_GAIN_MILLI[0], pgaMilli: PGA_GAIN_MILLI[0]};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state record
  assign regRdData = st_r.rdData;
  assign convIrq = st_r.irq;
  assign hvAmpEnable = st_r.hvEn;
  assign hvAmpGainMilli = st_r.hvMilli;
  assign pgaGainMilli = st_r.pgaMilli;
  assign converterPowered = st_r.cnEn;
  assign trackOn = st_r.trackOn;
  assign convActive = st_r.conv;
  assign sarTick = st_r.tick;

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // With a divider setting of two (SAR clock is core clock over three), two quiet cycles separate SAR ticks
  sequence tickGap2;
    !tickNow ##1 !tickNow ##1 (tickNow || !st_r.cnEn || st_r.fsm == ST_IDLE);
  endsequence

  chk_conv_sets_done: assert property (convEnd |=> st_r.done && st_r.fsm == ST_IDLE)
    else $error("completion did not set done flag");
  chk_done_sticky: assert property (st_r.done && !wrCtrl |=> st_r.done)
    else $error("done flag cleared without software");
  chk_win_sticky: assert property (st_r.win && !wrCtrl |=> st_r.win)
    else $error("window flag cleared without software");
  chk_track_three: assert property (st_r.fsm == ST_TRACK && tickNow && st_r.stepCnt == 4'h2 && st_r.cnEn
    |=> st_r.fsm == ST_CONV && st_r.stepCnt == 4'h0)
    else $error("low-power track not three SAR clocks");
  chk_shutdown_idle: assert property (!st_r.cnEn |=> st_r.fsm == ST_IDLE && !convActive)
    else $error("disabled converter not idle");
  chk_wr_zero_idle: assert property (st_r.fsm == ST_IDLE && st_r.src == SRC_SOFT && wrCtrl
    && !regWrData[CTRL_BUSY_BIT] |=> st_r.fsm == ST_IDLE)
    else $error("busy write of zero started conversion");
  chk_sar_divide: assert property (tickNow && st_r.sarDiv == 5'h02 && st_r.fsm == ST_CONV
    && !convEnd |=> tickGap2)
    else $error("SAR clock not core clock over three");
  chk_ljst_zero: assert property (regAddr == RES_LOW_OFFSET && st_r.ljst |=> regRdData[5:0] == 6'h00)
    else $error("left-justified low byte not zero-filled");
  chk_busy_read: assert property (regAddr == CTRL_OFFSET |=> regRdData[4] == $past(busyNow))
    else $error("busy bit does not follow conversion");
  chk_track_cont: assert property (!st_r.tm && st_r.cnEn |-> trackOn == (st_r.fsm != ST_CONV))
    else $error("continuous tracking wrong");
  chk_hv_enable: assert property (wrHv ##1 !wrHv |-> hvAmpEnable == $past(regWrData[HV_EN_BIT]))
    else $error("amplifier enable not from bit 7");

  // Start sources: an enabled, idle converter leaves idle on its own event only
  chk_soft_start: assert property (st_r.fsm == ST_IDLE && st_r.cnEn && st_r.src == SRC_SOFT && wrCtrl
    && regWrData[CTRL_BUSY_BIT] |=> st_r.fsm != ST_IDLE)
    else $error("busy write of one did not start");
  chk_timer_start: assert property (st_r.fsm == ST_IDLE && st_r.cnEn &&
    ((st_r.src == SRC_TIMER_B && timerBOvf) || (st_r.src == SRC_TIMER_A && timerAOvf)) |=> st_r.fsm != ST_IDLE)
    else $error("timer overflow did not start");
  chk_strobe_direct: assert property (st_r.fsm == ST_IDLE && st_r.cnEn && st_r.src == SRC_STROBE && strobeRise
    |=> st_r.fsm == ST_CONV)
    else $error("strobe rise did not convert at once");
  chk_strobe_track: assert property (st_r.fsm == ST_IDLE && st_r.cnEn && st_r.tm && st_r.src == SRC_STROBE
    && !extConvStrobe && !wrCtrl |=> trackOn)
    else $error("no tracking while strobe low");

  // Tracking switch against the sequencer state
  chk_track_lp: assert property (st_r.fsm == ST_TRACK && st_r.cnEn |-> trackOn && !convActive)
    else $error("low-power track switch open");
  chk_conv_no_track: assert property (convActive |-> !trackOn)
    else $error("tracking while converting");

  // Flags and interrupt request; a disabled converter leaves them alone
  chk_disabled_flags: assert property (!st_r.cnEn && !wrCtrl
    |=> $stable(st_r.done) && $stable(st_r.win) && !convIrq)
    else $error("disabled converter changed a flag");
  chk_irq_gate: assert property (convEnd |=> convIrq == $past(convIrqEnable))
    else $error("interrupt request not gated by enable");
  chk_win_set: assert property (convEnd && winHit |=> st_r.win)
    else $error("window match did not set flag");

  // Right-justified high byte: zero fill or sign extension
  chk_rj_zero_fill: assert property (regAddr == RES_HIGH_OFFSET && !st_r.ljst && !st_r.resDiff
    |=> regRdData[7:2] == 6'h00)
    else $error("single-ended high byte not zero-filled");
  chk_rj_sign_fill: assert property (regAddr == RES_HIGH_OFFSET && !st_r.ljst && st_r.resDiff && st_r.result[9]
    |=> regRdData[7:2] == 6'h3F)
    else $error("differential high byte not sign-extended");

endmodule

// ### verif/sac_front_end_model.sv
`timescale 1ns/1ps
// --------------------------------------------------------------
// Analog front end model
// --------------------------------------------------------------
module sac_front_end_model (
  input wire logic convActive, // Conversion running
  input wire logic [9:0] codeSet, // Code chosen by the bench
  input wire logic diffSet, // Differential reading chosen by the bench
  output logic [9:0] analogResult, // Code to the sequencer
  output logic diffMode // Differential flag to the sequencer
);
  // Inverted outside a conversion, so a sample taken too early cannot match
  always_comb begin
    analogResult = convActive ? codeSet : ~codeSet;
    diffMode = convActive ? diffSet : ~diffSet;
  end
endmodule

// ### verif/tb_sar_adc_sequencing_control.sv
`timescale 1ns/1ps
module tb_sar_adc_sequencing_control import sac_pkg::*;;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData;
  logic regWrEn = 1'b0, timerAOvf = 1'b0, timerBOvf = 1'b0, extConvStrobe = 1'b0;
  logic diffSet = 1'b0, convIrqEnable = 1'b1, diffMode, convIrq, hvAmpEnable;
  logic converterPowered, trackOn, convActive, sarTick;
  logic [9:0] codeSet = 10'h02A5, analogResult;
  logic [15:0] ltLimit = 16'h8000, gtLimit = 16'h7FFF;
  logic [13:0] hvAmpGainMilli, pgaGainMilli;
  logic [13:0] hvTab [16] = '{14'h0032, 14'h0064, 14'h007D, 14'h00C8, 14'h00FA, 14'h0190, 14'h01F4,
    14'h0320, 14'h03E8, 14'h0640, 14'h07D0, 14'h0C80, 14'h0FA0, 14'h1838, 14'h1DB0, 14'h36B0};
  logic [13:0] pgaTab [8] = '{14'h03E8, 14'h07D0, 14'h0FA0, 14'h1F40, 14'h3E80, 14'h3E80, 14'h01F4, 14'h01F4};
  int miscompares = 0, samples_checked = 0, irqCnt = 0, trkTicks = 0, cyc = 0, lastT = 0, gap = 0;

  always #25 clk = ~clk;

  sac_sequencer #(.CONV_SAR_CLKS(3)) dut_u (.clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdData(regRdData), .timerAOvf(timerAOvf), .timerBOvf(timerBOvf),
    .extConvStrobe(extConvStrobe), .analogResult(analogResult), .diffMode(diffMode), .ltLimit(ltLimit),
    .gtLimit(gtLimit), .convIrqEnable(convIrqEnable), .convIrq(convIrq), .hvAmpEnable(hvAmpEnable),
    .hvAmpGainMilli(hvAmpGainMilli), .pgaGainMilli(pgaGainMilli), .converterPowered(converterPowered),
    .trackOn(trackOn), .convActive(convActive), .sarTick(sarTick));
  sac_front_end_model model_u (.convActive(convActive), .codeSet(codeSet), .diffSet(diffSet),
    .analogResult(analogResult), .diffMode(diffMode));

  // Event counters: interrupts, ticks spent tracking, spacing of SAR ticks
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (convIrq === 1'b1) irqCnt <= irqCnt + 1;
    if (sarTick === 1'b1 && trackOn === 1'b1 && convActive !== 1'b1) trkTicks <= trkTicks + 1;
    if (sarTick === 1'b1 && convActive === 1'b1) begin
      gap <= cyc - lastT;
      lastT <= cyc;
    end
  end

  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge clk);
    regWrEn = 1'b0;
  endtask

  // Read data is registered, so it is taken one cycle after the address
  task automatic rc(input logic [7:0] a, input logic [7:0] e, input string msg);
    @(negedge clk);
    regAddr = a;
    @(negedge clk);
    chk(16'(regRdData), 16'(e), msg);
  endtask

  // Poll done, check result and flags, clear them, then pace the next start
  task automatic finish_conv(input logic [7:0] ctl, input logic [7:0] flags, input logic [15:0] exp);
    int i;
    // Hold the control address and watch the done bit; busy reads are not final values
    @(negedge clk);
    regAddr = CTRL_OFFSET;
    @(negedge clk);
    for (i = 0; i < 100 && regRdData[5] !== 1'b1; i++) @(negedge clk);
    chk(16'(regRdData[5]), 16'h0001, "poll");
    rc(RES_HIGH_OFFSET, exp[15:8], "result high");
    rc(RES_LOW_OFFSET, exp[7:0], "result low");
    rc(CTRL_OFFSET, ctl | flags, "flags held");
    wr(CTRL_OFFSET, ctl);
    rc(CTRL_OFFSET, ctl, "flags cleared");
    repeat (200) @(negedge clk);
  endtask

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_reset;
    rc(CFG_OFFSET, 8'hF8, "cfg reset");
    rc(HV_OFFSET, 8'h00, "amp reset");
    rc(CTRL_OFFSET, 8'h00, "ctrl reset");
    rc(8'h55, 8'h00, "unmapped");
    chk(16'(pgaGainMilli), 16'h03E8, "pga reset");
    chk(16'(hvAmpGainMilli), 16'h0032, "amp gain reset");
    $display("reset test done");
  endtask

  // Every amplifier and converter gain code; reserved amplifier bits read zero
  task automatic t_gains;
    for (int i = 0; i < 16; i++) begin
      wr(HV_OFFSET, 8'h80 | 8'(i));
      wr(CFG_OFFSET, 8'h10 | 8'(i & 7));
      chk(16'(hvAmpGainMilli), 16'(hvTab[i]), "amp gain");
      chk(16'(hvAmpEnable), 16'h0001, "amp on");
      chk(16'(pgaGainMilli), 16'(pgaTab[i & 7]), "pga gain");
    end
    wr(HV_OFFSET, 8'h7F);
    rc(HV_OFFSET, 8'h0F, "amp readback");
    chk(16'(hvAmpEnable), 16'h0000, "amp off");
    $display("gain test done");
  endtask

  // Disabled and wrong-source busy writes ignored, then a polled soft start
  task automatic t_soft;
    int i0;
    wr(CTRL_OFFSET, 8'h10);
    rc(CTRL_OFFSET, 8'h00, "disabled start");
    wr(CTRL_OFFSET, 8'h84);
    wr(CTRL_OFFSET, 8'h94);
    rc(CTRL_OFFSET, 8'h84, "busy write src 01");
    wr(CTRL_OFFSET, 8'h80);
    chk(16'({converterPowered, trackOn}), 16'h0003, "idle tracking");
    i0 = irqCnt;
    wr(CTRL_OFFSET, 8'h90);
    rc(CTRL_OFFSET, 8'h90, "busy");
    chk(16'(trackOn), 16'h0000, "hold while converting");
    finish_conv(8'h80, 8'h20, 16'h02A5);
    chk(16'(gap), 16'h0003, "sar period");
    chk(16'(irqCnt - i0), 16'h0001, "irq pulse");
    $display("soft start test done");
  endtask

  // Timer and strobe sources, left-justified differential, interrupt gated off
  task automatic t_sources;
    int i0;
    i0 = irqCnt;
    convIrqEnable = 1'b0;
    diffSet = 1'b1;
    codeSet = 10'h03F0;
    for (int s = 1; s < 4; s++) begin
      wr(CTRL_OFFSET, 8'h81 | 8'(s << 2));
      timerBOvf = (s == 1);
      extConvStrobe = (s == 2);
      timerAOvf = (s == 3);
      @(negedge clk);
      timerAOvf = 1'b0;
      timerBOvf = 1'b0;
      finish_conv(8'h81 | 8'(s << 2), 8'h20, 16'hFC00);
    end
    extConvStrobe = 1'b0;
    chk(16'(irqCnt - i0), 16'h0000, "irq gated");
    convIrqEnable = 1'b1;
    $display("source test done");
  endtask

  // Right-justified differential result -16 against signed windows
  task automatic t_window;
    ltLimit = 16'h0000;
    gtLimit = 16'hFFE0;
    // Source must already read 00 when the busy bit is written
    wr(CTRL_OFFSET, 8'h80);
    wr(CTRL_OFFSET, 8'h90);
    finish_conv(8'h80, 8'h22, 16'hFFF0);
    ltLimit = 16'h0010;
    gtLimit = 16'h0000;
    wr(CTRL_OFFSET, 8'h90);
    finish_conv(8'h80, 8'h20, 16'hFFF0);
    ltLimit = 16'h8000;
    gtLimit = 16'h7FFF;
    $display("window test done");
  endtask

  // Low-power tracking: three SAR ticks before soft and timer starts, strobe level tracking
  task automatic t_lowpower;
    int t0;
    diffSet = 1'b0;
    codeSet = 10'h0155;
    wr(CTRL_OFFSET, 8'hC0);
    t0 = trkTicks;
    wr(CTRL_OFFSET, 8'hD0);
    finish_conv(8'hC0, 8'h20, 16'h0155);
    chk(16'(trkTicks - t0), 16'h0003, "soft track ticks");
    wr(CTRL_OFFSET, 8'hCC);
    t0 = trkTicks;
    timerAOvf = 1'b1;
    @(negedge clk);
    timerAOvf = 1'b0;
    finish_conv(8'hCC, 8'h20, 16'h0155);
    chk(16'(trkTicks - t0), 16'h0003, "timer track ticks");
    extConvStrobe = 1'b1;
    wr(CTRL_OFFSET, 8'hC8);
    chk(16'(trackOn), 16'h0000, "strobe high idle");
    extConvStrobe = 1'b0;
    repeat (2) @(negedge clk);
    chk(16'(trackOn), 16'h0001, "strobe low tracks");
    extConvStrobe = 1'b1;
    finish_conv(8'hC8, 8'h20, 16'h0155);
    $display("low power test done");
  endtask

  initial begin
    #2000000;
    miscompares++;
    $display("wrong value at %0t: watchdog expired", $time);
    close_out;
  end

  initial begin
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    t_reset;
    t_gains;
    t_soft;
    t_sources;
    t_window;
    t_lowpower;
    close_out;
  end
endmodule
